// [core/fdc_pm_consts.svh]
// constants for the floppy controller power manager and its host bridge
`ifndef FDC_PM_CONSTS_SVH
`define FDC_PM_CONSTS_SVH
// host port offsets
`define OFS_STAT_A 3'h0
`define OFS_CFG_INDEX 3'h0
`define OFS_STAT_B 3'h1
`define OFS_CFG_DATA 3'h1
`define OFS_DRV_CTL 3'h2
`define OFS_RATE_STAT 3'h4
`define OFS_FIFO 3'h5
`define OFS_DISK_RATE 3'h7
// key values
`define UNLOCK_KEY 8'h55
`define LOCK_KEY 8'hAA
`define IDLE_MAIN_STAT 8'h80
// field positions
`define DRV_MOTOR_LSB 4
`define DRV_DMA_EN_BIT 3
`define DRV_RESET_N_BIT 2
`define RATE_RESET_BIT 7
`define RATE_PD_BIT 6
`define CFG_APD_REG 5'h07
`define CFG_APD_BIT 7
`define CFG_ID_REG 5'h0D
`define CFG_REV_REG 5'h0E
// reset values
`define DRV_CTL_RST 8'h04
`define RATE_SEL_RST 8'h00
`define CFG_RATE_RST 8'h00
`define CR00_RST 8'h28
`define CR01_RST 8'h90
`define CR03_RST 8'h70
`define CR06_RST 8'hFF
// timing
`define CLK_MHZ 50
`define APD_TIME_US 10000
`define SW_RST_CYC 4'h8
`define STROBE_CYC 3'h4
// host bridge register offsets
`define HOST_CMD_OFS 12'h000
`define HOST_STAT_OFS 12'h004
`define HOST_CTRL_OFS 12'h008
`define CMD_GO_BIT 31
`define CMD_WRITE_BIT 16
`endif

// [core/fdc_pm_pkg.sv]
// types shared by both ends of the floppy controller host port
package fdc_pm_pkg;
  typedef enum logic [1:0] {PWR_AWAKE, PWR_AUTO_DOWN, PWR_DSR_DOWN} pwr_st_t;
  typedef enum logic [1:0] {CFG_IDLE, CFG_ARMED, CFG_MODE} cfg_st_t;
  typedef enum logic [1:0] {HST_IDLE, HST_SETUP, HST_STROBE, HST_RECOVER} host_st_t;

  typedef struct packed {
    pwr_st_t pwr;
    cfg_st_t cfg_st;
    logic [4:0] cfg_idx;
    logic [31:0][7:0] cfg;
    logic [7:0] drv_ctl;
    logic [7:0] rate_sel;
    logic [7:0] cfg_rate;
    logic [7:0] eff_drv_ctl;
    logic [7:0] eff_cfg_rate;
    logic [19:0] apd_cnt;
    logic [3:0] rst_cnt;
    logic ior_q;
    logic iow_q;
    logic [7:0] rdata;
    logic irq;
    logic drq;
    logic fifo_rd;
    logic fifo_wr;
    logic [7:0] fifo_wdata;
    logic core_rst;
    logic low_power;
    logic [3:0] motor;
    logic [3:0] dsel;
    logic drv_oe;
    logic wr_data;
    logic wr_en;
    logic step;
    logic step_dir;
    logic head;
    logic density;
    logic [1:0] rate;
    logic dma_ack;
    logic term_cnt;
    logic [1:0] track_zero_in_s;
    logic [1:0] idx_s;
    logic [1:0] dchg_s;
    logic [1:0] second_drive_present_in_s;
  } dev_state_t;

  typedef struct packed {
    host_st_t st;
    logic [2:0] cmd_addr;
    logic [7:0] cmd_data;
    logic cmd_wr;
    logic busy;
    logic [7:0] rdata_last;
    logic [2:0] cnt;
    logic cs_n;
    logic ior_n;
    logic iow_n;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic bus_rst;
    logic dma_ack_n;
    logic term_cnt;
    logic [31:0] prdata;
    logic pready;
  } host_state_t;
endpackage

// [core/fdc_bus_if.sv]
// host i/o port between the bus bridge and the floppy controller
interface fdc_bus_if;
  logic cs_n;
  logic ior_n;
  logic iow_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic bus_rst;
  logic dma_ack_n;
  logic term_cnt;
  logic irq;
  logic drq;
  modport device (input cs_n, ior_n, iow_n, addr, wdata, bus_rst, dma_ack_n, term_cnt, output rdata, irq, drq);
  modport host (output cs_n, ior_n, iow_n, addr, wdata, bus_rst, dma_ack_n, term_cnt, input rdata, irq, drq);
endinterface

// [core/fdc_pm_device.sv]
// floppy controller host port with auto powerdown and configuration access
`include "fdc_pm_consts.svh"
module fdc_pm_device #(
  parameter int APD_CYCLES = `APD_TIME_US * `CLK_MHZ,
  parameter logic [7:0] DEVICE_ID = 8'h5A
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // host port
  fdc_bus_if.device bus,
  // controller core
  input wire logic [7:0] core_status_in,
  input wire logic core_int_in,
  input wire logic core_drq_in,
  input wire logic head_unload_done_in,
  input wire logic [7:0] fifo_rdata_in,
  output logic fifo_rd_out,
  output logic fifo_wr_out,
  output logic [7:0] fifo_wdata_out,
  output logic core_reset_out,
  output logic low_power_out,
  output logic dma_acknowledge_in,
  output logic terminal_count_in,
  input wire logic core_step_in,
  input wire logic core_dir_in,
  input wire logic core_head_in,
  input wire logic core_wr_data_in,
  input wire logic core_wr_en_in,
  // drive pins
  output logic [3:0] motor_enable_out,
  output logic motor_enable_oe,
  output logic [3:0] drive_select_out,
  output logic drive_select_oe,
  output logic write_data_out,
  output logic write_data_oe,
  output logic write_enable_out,
  output logic write_enable_oe,
  output logic step_out,
  output logic step_dir_out,
  output logic head_select_out,
  output logic density_select_out,
  output logic [1:0] data_rate_out,
  input wire logic track_zero_in,
  input wire logic index_pulse_in,
  input wire logic disk_change_in,
  input wire logic second_drive_present_in
);
  // ************************************************************
  // reset image
  // ************************************************************
  function automatic fdc_pm_pkg::dev_state_t rst_state();
    fdc_pm_pkg::dev_state_t r;
    r = '0;
    r.pwr = fdc_pm_pkg::PWR_AWAKE;
    r.cfg_st = fdc_pm_pkg::CFG_IDLE;
    r.cfg[0] = `CR00_RST;
    r.cfg[1] = `CR01_RST;
    r.cfg[3] = `CR03_RST;
    r.cfg[6] = `CR06_RST;
    r.cfg[`CFG_ID_REG] = DEVICE_ID; // id value is arbitrary
    r.drv_ctl = `DRV_CTL_RST;
    r.rate_sel = `RATE_SEL_RST;
    r.cfg_rate = `CFG_RATE_RST;
    r.eff_drv_ctl = `DRV_CTL_RST;
    r.eff_cfg_rate = `CFG_RATE_RST;
    r.ior_q = 1'b1;
    r.iow_q = 1'b1;
    r.core_rst = 1'b1;
    r.drv_oe = 1'b1;
    return r;
  endfunction
  localparam fdc_pm_pkg::dev_state_t RST = rst_state();

  fdc_pm_pkg::dev_state_t s_ff;
  fdc_pm_pkg::dev_state_t nxt_s;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic sel;
    logic rd_ev;
    logic wr_ev;
    logic [2:0] a;
    logic [7:0] d;
    logic sw_rst;
    logic wake_acc;
    logic restart;
    logic apd_en;
    logic cond_ok;
    logic down;
    sel = 1'b0;
    rd_ev = 1'b0;
    wr_ev = 1'b0;
    a = 3'h0;
    d = 8'h00;
    sw_rst = 1'b0;
    wake_acc = 1'b0;
    restart = 1'b0;
    apd_en = 1'b0;
    cond_ok = 1'b0;
    down = 1'b0;
    nxt_s = s_ff;
    // host inputs keep being watched whatever the power state
    sel = ~bus.cs_n;
    a = bus.addr;
    d = bus.wdata;
    rd_ev = sel & ~bus.ior_n & s_ff.ior_q;
    wr_ev = sel & ~bus.iow_n & s_ff.iow_q;
    nxt_s.ior_q = bus.ior_n;
    nxt_s.iow_q = bus.iow_n;
    nxt_s.dma_ack = ~bus.dma_ack_n;
    nxt_s.term_cnt = bus.term_cnt;
    // drive status stays an input; two-stage synchronisers
    nxt_s.track_zero_in_s = {s_ff.track_zero_in_s[0], track_zero_in};
    nxt_s.idx_s = {s_ff.idx_s[0], index_pulse_in};
    nxt_s.dchg_s = {s_ff.dchg_s[0], disk_change_in};
    nxt_s.second_drive_present_in_s = {s_ff.second_drive_present_in_s[0], second_drive_present_in};
    nxt_s.fifo_rd = 1'b0;
    nxt_s.fifo_wr = 1'b0;
    if (s_ff.rst_cnt != 4'h0)
    begin
      nxt_s.rst_cnt = s_ff.rst_cnt - 4'h1;
    end
    // writes are stored whatever the power state
    if (wr_ev && a == `OFS_DRV_CTL)
    begin
      nxt_s.drv_ctl = d;
      sw_rst = ~d[`DRV_RESET_N_BIT];
      wake_acc = |d[7:`DRV_MOTOR_LSB];
    end
    else if (wr_ev && a == `OFS_RATE_STAT)
    begin
      nxt_s.rate_sel = {1'b0, d[6:0]};
      sw_rst = d[`RATE_RESET_BIT];
    end
    else if (wr_ev && a == `OFS_DISK_RATE)
    begin
      nxt_s.cfg_rate = d;
    end
    else if ((rd_ev || wr_ev) && a == `OFS_FIFO)
    begin
      wake_acc = 1'b1;
      restart = 1'b1;
      nxt_s.fifo_rd = rd_ev;
      nxt_s.fifo_wr = wr_ev;
      nxt_s.fifo_wdata = d;
    end
    else if (rd_ev && a == `OFS_RATE_STAT)
    begin
      wake_acc = 1'b1;
      restart = 1'b1;
    end
    if (sw_rst)
    begin
      nxt_s.rst_cnt = `SW_RST_CYC;
    end
    // configuration unlock, index and data, only while selected
    if (wr_ev)
    begin
      case (s_ff.cfg_st)
        fdc_pm_pkg::CFG_IDLE:
        begin
          if (a == `OFS_CFG_INDEX && d == `UNLOCK_KEY)
          begin
            nxt_s.cfg_st = fdc_pm_pkg::CFG_ARMED;
          end
        end
        fdc_pm_pkg::CFG_ARMED:
        begin
          if (a == `OFS_CFG_INDEX && d == `UNLOCK_KEY)
          begin
            nxt_s.cfg_st = fdc_pm_pkg::CFG_MODE;
          end
          else
          begin
            nxt_s.cfg_st = fdc_pm_pkg::CFG_IDLE;
          end
        end
        fdc_pm_pkg::CFG_MODE:
        begin
          if (a == `OFS_CFG_INDEX && d == `LOCK_KEY)
          begin
            nxt_s.cfg_st = fdc_pm_pkg::CFG_IDLE;
          end
          else if (a == `OFS_CFG_INDEX)
          begin
            nxt_s.cfg_idx = d[4:0];
          end
          else if (a == `OFS_CFG_DATA && s_ff.cfg_idx != `CFG_ID_REG && s_ff.cfg_idx != `CFG_REV_REG)
          begin
            nxt_s.cfg[s_ff.cfg_idx] = d;
          end
        end
        default:
        begin
          nxt_s.cfg_st = fdc_pm_pkg::CFG_IDLE;
        end
      endcase
    end
    // read data follows the strobe; reads show live status
    if (sel && !bus.ior_n)
    begin
      if (s_ff.cfg_st == fdc_pm_pkg::CFG_MODE && a == `OFS_CFG_DATA)
      begin
        nxt_s.rdata = s_ff.cfg[s_ff.cfg_idx];
      end
      else if (a == `OFS_STAT_A)
      begin
        nxt_s.rdata = {core_int_in, 3'b000, s_ff.second_drive_present_in_s[1], s_ff.idx_s[1], 1'b0, s_ff.track_zero_in_s[1]};
      end
      else if (a == `OFS_STAT_B)
      begin
        nxt_s.rdata = {2'b11, s_ff.drv_ctl[5:4], 3'b000, s_ff.drv_ctl[0]};
      end
      else if (a == `OFS_DRV_CTL)
      begin
        nxt_s.rdata = s_ff.drv_ctl; // reading never wakes
      end
      else if (a == `OFS_RATE_STAT)
      begin
        nxt_s.rdata = core_status_in;
      end
      else if (a == `OFS_FIFO)
      begin
        nxt_s.rdata = fifo_rdata_in;
      end
      else if (a == `OFS_DISK_RATE)
      begin
        nxt_s.rdata = {s_ff.dchg_s[1], 7'h00};
      end
      else
      begin
        nxt_s.rdata = 8'h00;
      end
    end
    // ************************************************************
    // power state
    // ************************************************************
    apd_en = s_ff.cfg[`CFG_APD_REG][`CFG_APD_BIT];
    cond_ok = s_ff.drv_ctl[7:`DRV_MOTOR_LSB] == 4'h0 && core_status_in == `IDLE_MAIN_STAT && !core_int_in
      && head_unload_done_in && s_ff.apd_cnt == 20'(APD_CYCLES);
    case (s_ff.pwr)
      fdc_pm_pkg::PWR_AWAKE:
      begin
        if (!apd_en || restart)
        begin
          nxt_s.apd_cnt = 20'h0_0000;
        end
        else if (s_ff.apd_cnt != 20'(APD_CYCLES))
        begin
          nxt_s.apd_cnt = s_ff.apd_cnt + 20'h0_0001;
        end
        if (apd_en && cond_ok && !wake_acc && !sw_rst)
        begin
          nxt_s.pwr = fdc_pm_pkg::PWR_AUTO_DOWN;
        end
      end
      fdc_pm_pkg::PWR_AUTO_DOWN:
      begin
        // register wake keeps every register as it stands
        if (wake_acc || sw_rst || !apd_en)
        begin
          nxt_s.pwr = fdc_pm_pkg::PWR_AWAKE;
          nxt_s.apd_cnt = 20'h0_0000;
        end
      end
      default:
      begin
        // only a reset ends a rate-select powerdown
        if (sw_rst)
        begin
          nxt_s.pwr = fdc_pm_pkg::PWR_AWAKE;
          nxt_s.apd_cnt = 20'h0_0000;
        end
      end
    endcase
    if (wr_ev && a == `OFS_RATE_STAT && d[`RATE_PD_BIT] && !sw_rst)
    begin
      nxt_s.pwr = fdc_pm_pkg::PWR_DSR_DOWN;
    end
    // bus reset pin: full reset, config registers survive
    if (bus.bus_rst)
    begin
      nxt_s.pwr = fdc_pm_pkg::PWR_AWAKE;
      nxt_s.apd_cnt = 20'h0_0000;
      nxt_s.drv_ctl = `DRV_CTL_RST;
      nxt_s.rate_sel = `RATE_SEL_RST;
      nxt_s.cfg_rate = `CFG_RATE_RST;
      nxt_s.rst_cnt = `SW_RST_CYC;
    end
    // ************************************************************
    // pins
    // ************************************************************
    down = nxt_s.pwr != fdc_pm_pkg::PWR_AWAKE;
    // stored writes take effect only once awake
    if (!down)
    begin
      nxt_s.eff_drv_ctl = nxt_s.drv_ctl;
      nxt_s.eff_cfg_rate = nxt_s.cfg_rate;
    end
    nxt_s.core_rst = bus.bus_rst | ~nxt_s.drv_ctl[`DRV_RESET_N_BIT] | (nxt_s.rst_cnt != 4'h0);
    // brief power rise while the host strobes, then low again
    nxt_s.low_power = down & ~(sel & (~bus.ior_n | ~bus.iow_n));
    nxt_s.irq = ~down & core_int_in & nxt_s.eff_drv_ctl[`DRV_DMA_EN_BIT];
    nxt_s.drq = ~down & core_drq_in & nxt_s.eff_drv_ctl[`DRV_DMA_EN_BIT];
    nxt_s.drv_oe = ~down;
    nxt_s.motor = nxt_s.eff_drv_ctl[7:`DRV_MOTOR_LSB];
    nxt_s.dsel = 4'h1 << nxt_s.eff_drv_ctl[1:0];
    nxt_s.wr_data = core_wr_data_in;
    nxt_s.wr_en = core_wr_en_in;
    // these stay driven through powerdown
    nxt_s.step = core_step_in;
    nxt_s.step_dir = core_dir_in;
    nxt_s.head = core_head_in;
    nxt_s.rate = nxt_s.eff_cfg_rate[1:0];
    nxt_s.density = nxt_s.eff_cfg_rate[1:0] != 2'h2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff <= RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus.rdata = s_ff.rdata;
  assign bus.irq = s_ff.irq;
  assign bus.drq = s_ff.drq;
  assign fifo_rd_out = s_ff.fifo_rd;
  assign fifo_wr_out = s_ff.fifo_wr;
  assign fifo_wdata_out = s_ff.fifo_wdata;
  assign core_reset_out = s_ff.core_rst;
  assign low_power_out = s_ff.low_power;
  assign dma_acknowledge_in = s_ff.dma_ack;
  assign terminal_count_in = s_ff.term_cnt;
  assign motor_enable_out = s_ff.motor;
  assign motor_enable_oe = s_ff.drv_oe;
  assign drive_select_out = s_ff.dsel;
  assign drive_select_oe = s_ff.drv_oe;
  assign write_data_out = s_ff.wr_data;
  assign write_data_oe = s_ff.drv_oe;
  assign write_enable_out = s_ff.wr_en;
  assign write_enable_oe = s_ff.drv_oe;
  assign step_out = s_ff.step;
  assign step_dir_out = s_ff.step_dir;
  assign head_select_out = s_ff.head;
  assign density_select_out = s_ff.density;
  assign data_rate_out = s_ff.rate;
endmodule

// [core/fdc_pm_host.sv]
// apb-driven host bridge issuing i/o cycles to the floppy controller
`include "fdc_pm_consts.svh"
module fdc_pm_host (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller port
  fdc_bus_if.host bus
);
  fdc_pm_pkg::host_state_t s_ff;
  fdc_pm_pkg::host_state_t nxt_s;

  always_comb
  begin
    logic wr_go;
    wr_go = 1'b0;
    nxt_s = s_ff;
    // ************************************************************
    // apb: answer ready one cycle after setup
    // ************************************************************
    nxt_s.pready = psel & ~penable;
    if (psel && !penable)
    begin
      if (paddr == `HOST_STAT_OFS)
      begin
        nxt_s.prdata = {16'h0000, s_ff.rdata_last, 7'h00, s_ff.busy};
      end
      else if (paddr == `HOST_CTRL_OFS)
      begin
        nxt_s.prdata = {31'h0000_0000, s_ff.bus_rst};
      end
      else
      begin
        nxt_s.prdata = 32'h0000_0000;
      end
    end
    if (psel && penable && s_ff.pready && pwrite)
    begin
      if (paddr == `HOST_CMD_OFS)
      begin
        wr_go = pwdata[`CMD_GO_BIT] & ~s_ff.busy;
      end
      else if (paddr == `HOST_CTRL_OFS)
      begin
        nxt_s.bus_rst = pwdata[0];
      end
    end
    // ************************************************************
    // i/o cycle: one at a time, so unlock pairs stay adjacent
    // ************************************************************
    case (s_ff.st)
      fdc_pm_pkg::HST_IDLE:
      begin
        if (wr_go)
        begin
          nxt_s.busy = 1'b1;
          nxt_s.cmd_wr = pwdata[`CMD_WRITE_BIT];
          nxt_s.cmd_addr = pwdata[10:8];
          nxt_s.cmd_data = pwdata[7:0];
          nxt_s.st = fdc_pm_pkg::HST_SETUP;
        end
      end
      fdc_pm_pkg::HST_SETUP:
      begin
        // chip select with address: config decode needs it
        nxt_s.cs_n = 1'b0;
        nxt_s.addr = s_ff.cmd_addr;
        nxt_s.wdata = s_ff.cmd_data;
        nxt_s.st = fdc_pm_pkg::HST_STROBE;
        nxt_s.cnt = `STROBE_CYC;
      end
      fdc_pm_pkg::HST_STROBE:
      begin
        nxt_s.ior_n = s_ff.cmd_wr;
        nxt_s.iow_n = ~s_ff.cmd_wr;
        nxt_s.cnt = s_ff.cnt - 3'h1;
        if (s_ff.cnt == 3'h1)
        begin
          nxt_s.st = fdc_pm_pkg::HST_RECOVER;
        end
      end
      default:
      begin
        if (!s_ff.cmd_wr)
        begin
          nxt_s.rdata_last = bus.rdata;
        end
        nxt_s.ior_n = 1'b1;
        nxt_s.iow_n = 1'b1;
        nxt_s.cs_n = 1'b1;
        nxt_s.busy = 1'b0;
        nxt_s.st = fdc_pm_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff <= '{st: fdc_pm_pkg::HST_IDLE, cs_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1, dma_ack_n: 1'b1, default: '0};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = 1'b0;
  assign bus.cs_n = s_ff.cs_n;
  assign bus.ior_n = s_ff.ior_n;
  assign bus.iow_n = s_ff.iow_n;
  assign bus.addr = s_ff.addr;
  assign bus.wdata = s_ff.wdata;
  assign bus.bus_rst = s_ff.bus_rst;
  assign bus.dma_ack_n = s_ff.dma_ack_n;
  assign bus.term_cnt = s_ff.term_cnt;
endmodule

// [tb/fdc_pm_sva.sv]
// concurrent checks on the host port between bridge and controller
module fdc_pm_sva (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // host port
  input logic cs_n,
  input logic ior_n,
  input logic iow_n,
  input logic [2:0] addr,
  input logic [7:0] wdata,
  input logic [7:0] rdata,
  input logic dma_ack_n,
  input logic term_cnt
);
  // ********************************
  // strobe framing
  // ********************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_frame;
    !iow_n [*4] ##1 (iow_n && cs_n);
  endsequence
  sequence s_rd_frame;
    !ior_n [*4] ##1 (ior_n && cs_n);
  endsequence
  a_write_strobe_len: assert property ($fell(iow_n) |-> s_wr_frame) else $error("write strobe length");
  a_read_strobe_len: assert property ($fell(ior_n) |-> s_rd_frame) else $error("read strobe length");
  a_strobe_excl: assert property (ior_n || iow_n) else $error("both strobes low");
  a_select_wrap: assert property ((!ior_n || !iow_n) |-> !cs_n) else $error("strobe without select");
  a_select_lead: assert property ($fell(cs_n) |=> ($fell(ior_n) || $fell(iow_n))) else $error("no strobe");
  // unlock counting relies on a steady address and data per access
  a_addr_hold: assert property ((!cs_n && !$fell(cs_n)) |-> ($stable(addr) && $stable(wdata)))
    else $error("address moved");
  a_rdata_hold: assert property ($past(ior_n) |-> $stable(rdata)) else $error("read data moved");
  a_dma_idle: assert property (dma_ack_n && !term_cnt) else $error("dma inputs active");
endmodule

// [tb/fdc_auto_powerdown_config_access_test.sv]
// self-checking bench joining the apb bridge and the powerdown controller
module fdc_auto_powerdown_config_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [2:0] ofs; logic [7:0] d; logic wake; logic [1:0] rate;} row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, lp, moe, woe, crst, step;
  logic [3:0] mot;
  logic [1:0] rate;
  logic [8:0] pins = 9'h000;
  logic cint = 1'b0;
  logic [7:0] q;
  int bad_count = 0;
  int samples_checked = 0;
  // no wake rows first, with the rate reset row waking before the disk rate row, then each waking access; motor row last as it keeps the part awake
  row_t rows [12] = '{'{0, 0, 8'h00, 0, 0}, '{0, 1, 8'h00, 0, 0}, '{0, 7, 8'h00, 0, 0}, '{0, 2, 8'h00, 0, 0},
    '{1, 2, 8'h0C, 0, 0}, '{1, 4, 8'h00, 0, 0}, '{1, 4, 8'h80, 1, 0}, '{1, 7, 8'h02, 0, 0},
    '{0, 4, 8'h00, 1, 2}, '{0, 5, 8'h00, 1, 2}, '{1, 5, 8'h5A, 1, 2}, '{1, 2, 8'h14, 1, 2}};
  fdc_bus_if bus ();
  always #10 pclk = ~pclk;
  fdc_pm_host u_fdc_pm_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .bus(bus.host));
  fdc_pm_device #(.APD_CYCLES(40)) u_fdc_pm_device (.pclk(pclk), .presetn(presetn), .bus(bus.device),
    .core_status_in(8'h80), .core_int_in(cint), .core_drq_in(1'b1), .head_unload_done_in(1'b1),
    .fifo_rdata_in(8'h3C), .fifo_rd_out(), .fifo_wr_out(), .fifo_wdata_out(), .core_reset_out(crst),
    .low_power_out(lp), .dma_acknowledge_in(), .terminal_count_in(), .core_step_in(pins[0]),
    .core_dir_in(pins[1]), .core_head_in(pins[2]), .core_wr_data_in(pins[3]), .core_wr_en_in(pins[4]),
    .motor_enable_out(mot), .motor_enable_oe(moe), .drive_select_out(), .drive_select_oe(),
    .write_data_out(), .write_data_oe(woe), .write_enable_out(), .write_enable_oe(), .step_out(step),
    .step_dir_out(), .head_select_out(), .density_select_out(), .data_rate_out(rate),
    .track_zero_in(pins[5]), .index_pulse_in(pins[6]), .disk_change_in(pins[7]),
    .second_drive_present_in(pins[8]));
  fdc_pm_sva u_fdc_pm_sva (.pclk(pclk), .presetn(presetn), .cs_n(bus.cs_n), .ior_n(bus.ior_n),
    .iow_n(bus.iow_n), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .dma_ack_n(bus.dma_ack_n),
    .term_cnt(bus.term_cnt));
  // ********************************
  // tasks
  // ********************************
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one port cycle, then poll busy; read data comes back in status bits 15:8
  task io(input logic wr, input logic [2:0] ofs, input logic [7:0] d, output logic [7:0] r);
    apb(1'b1, 12'h000, {1'b1, 14'h0000, wr, 5'h00, ofs, d});
    // a stuck busy is left to the watchdog, which counts it as a failure
    do
    begin
      apb(1'b0, 12'h004, 32'h0000_0000);
    end
    while (rd[0] !== 1'b0);
    r = rd[15:8];
    @(posedge pclk);
  endtask
  task wait_pd(input logic exp);
    int n;
    n = 0;
    while (lp !== exp && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    check(lp, exp);
  endtask
  task cfg_write(input logic [7:0] idx, input logic [7:0] val);
    io(1'b1, 3'h0, 8'h55, q);
    io(1'b1, 3'h0, 8'h55, q);
    io(1'b1, 3'h0, idx, q);
    io(1'b1, 3'h1, val, q);
    io(1'b1, 3'h0, 8'hAA, q);
  endtask
  // ********************************
  // sequence
  // ********************************
  initial
  begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({lp, moe, pready}, 3'b010);
    io(1'b1, 3'h0, 8'h55, q);
    io(1'b1, 3'h0, 8'h55, q);
    io(1'b1, 3'h0, 8'h00, q);
    io(1'b0, 3'h1, 8'h00, q);
    check(q, 8'h28);
    io(1'b1, 3'h0, 8'hAA, q);
    cfg_write(8'h07, 8'h80);
    // a broken unlock must not let the later +0/+1 writes clear the enable
    io(1'b1, 3'h0, 8'h55, q);
    io(1'b1, 3'h2, 8'h04, q);
    io(1'b1, 3'h0, 8'h55, q);
    io(1'b1, 3'h0, 8'h07, q);
    io(1'b1, 3'h1, 8'h00, q);
    foreach (rows[i])
    begin
      wait_pd(1'b1);
      pins <= pins + 9'h0A5;
      repeat (3) @(posedge pclk);
      check({moe, woe}, 2'b00);
      check({bus.irq, bus.drq}, 2'b00);
      check(step, pins[0]);
      io(rows[i].wr, rows[i].ofs, rows[i].d, q);
      check(lp, !rows[i].wake);
      check(rate, rows[i].rate);
    end
    check({moe, mot}, 5'h11);
    io(1'b1, 3'h2, 8'h04, q);
    wait_pd(1'b1);
    io(1'b1, 3'h4, 8'h40, q);
    io(1'b0, 3'h4, 8'h00, q);
    check(lp, 1'b1);
    io(1'b1, 3'h4, 8'h80, q);
    check(lp, 1'b0);
    wait_pd(1'b1);
    apb(1'b1, 12'h008, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check({crst, lp}, 2'b10);
    apb(1'b1, 12'h008, 32'h0000_0000);
    repeat (12) @(posedge pclk);
    check({crst, rate}, 3'b000);
    // a pending interrupt must keep the part awake past the timer
    cint <= 1'b1;
    repeat (100) @(posedge pclk);
    check(lp, 1'b0);
    io(1'b0, 3'h0, 8'h00, q);
    check(q[7], 1'b1);
    cint <= 1'b0;
    wait_pd(1'b1);
    cfg_write(8'h07, 8'h00);
    repeat (100) @(posedge pclk);
    check(lp, 1'b0);
    print_verdict();
  end
endmodule
